// *** design/dpd_top.sv ***
/*
  dpd_top: configuration registers and integer divider path of a
  two-stage clock synthesizer (input prescaler, first-loop feedback and
  monitor dividers, second-loop pre-divider/doubler and feedback divider,
  five channel dividers, composite sysref rate divider).
  Assumes each oscillator edge arrives as a one-cycle tick synchronous
  to mclk_i, at most one tick per source per cycle.
*/
//
// Behaviour
// RL1: input prescaler divides by 1 to 4095, 12-bit field.
// RL2: first feedback divider 12 bits; monitor divider 9 bits, 4 to 511.
// RL3: second-loop pre-divider divides by 1 to 63, 6-bit field.
// RL4: second-loop feedback divider divides by 8 to 511, 9-bit field.
// RL5: five channel dividers, each 1 to 160, output is oscillator over value.
// RL6: sysref divider is product of four factor sets, 16 to 5120.
// RL7: bypass 0 runs first loop; 1 disables it, prescaled input feeds second loop.
// RL8: host sets manual input selection while first loop is bypassed.
// RL9: route 0: first loop feeds back through first feedback divider alone.
// RL10: route 1: feedback via second loop, monitor then first feedback divider.
// RL11: host picks cascaded route with pre-divider 1 for fixed delay.
// RL12: host sets monitor divider so its output matches input reference.
// RL13: doubler doubles first loop output and bypasses the pre-divider.
// RL14: host programs pre-divider when doubler is off, typically 1.
// RL15: host chooses divider values that let both loops lock.
// RL16: charge pump current 50 uA steps, 50 uA to 1.6 mA.
// RL17: host places first phase detector between 120 kHz and input rate.
// RL18: doubler 0 pre-divider divides; 1 doubles and pre-divider idle.
// RL19: host keeps monitor divider powered for loss-of-signal detection.
// RL20: each divider gives one pulse per N ticks, restarts on value change.
`timescale 1ns/1ps

module dpd_pdiv #(
  parameter int unsigned W = 12
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // divider control
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic [W-1:0] n_i,
  // ticks
  input wire logic tick_i,
  output logic tick_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] n_last;
  logic pulse;
  logic [W-1:0] next_cnt;
  logic [W-1:0] next_n_last;
  logic next_pulse;

  always_comb
  begin
    next_cnt = cnt;
    next_n_last = n_i;
    next_pulse = 1'b0;
    if (!en_i || clr_i || (n_i != n_last))
    begin
      next_cnt = '0; // see RL20
    end
    else if (tick_i)
    begin
      if (cnt >= W'(n_i - W'(1)))
      begin
        next_cnt = '0;
        next_pulse = 1'b1; // see RL20
      end
      else
      begin
        next_cnt = W'(cnt + W'(1));
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt <= '0;
      n_last <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      n_last <= next_n_last;
      pulse <= next_pulse;
    end
  end

  assign tick_o = pulse;
endmodule

module dpd_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [dpd_pkg::DPD_AW-1:0] addr_i,
  input wire logic [dpd_pkg::DPD_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [dpd_pkg::DPD_DW-1:0] rdata_o,
  // oscillator edge ticks
  input wire logic ref_tick_i,
  input wire logic vcxo_tick_i,
  input wire logic vco_tick_i,
  // loop controls
  output logic first_loop_enable_o,
  output logic [dpd_pkg::DPD_CP_W-1:0] cp_code_o,
  // divided ticks
  output dpd_pkg::dpd_ticks_t ticks_o,
  output logic [dpd_pkg::DPD_NCHAN-1:0] channel_tick_o
);
  import dpd_pkg::*;

  dpd_cfg_t cfg;
  dpd_cfg_t next_cfg;
  logic [DPD_NX_W-1:0] chan_div [DPD_NCHAN];
  logic [DPD_NX_W-1:0] next_chan_div [DPD_NCHAN];
  logic [DPD_DW-1:0] rdata;
  logic [DPD_DW-1:0] next_rdata;
  logic path_clr;
  logic next_path_clr;
  logic [15:0] sysref_val;
  logic [2:0] pow_sum;
  logic [4:0] stage_n [DPD_NSTAGE];
  logic [DPD_NSTAGE:0] stage_tick;
  logic pv_tick;
  logic mv1_tick;
  logic mv0_tick;
  logic mv0_src;
  logic second_src;
  logic pf_tick;
  logic dbl_tick;
  logic mf_tick;
  logic [DPD_PER_W-1:0] per_cnt;
  logic [DPD_PER_W-1:0] half_per;
  logic dbl_extra;
  logic [DPD_PER_W-1:0] next_per_cnt;
  logic [DPD_PER_W-1:0] next_half_per;
  logic next_dbl_extra;

  // sysref factors: {2,4} x {2,4,8,16} x {2,4,8,16} x {2,3,4,5}
  always_comb
  begin
    stage_n[0] = 5'(5'h02 << cfg.sysref_sel[DPD_B_SR0]); // see RL6
    stage_n[1] = 5'(5'h02 << cfg.sysref_sel[DPD_B_SR1 +: 2]);
    stage_n[2] = 5'(5'h02 << cfg.sysref_sel[DPD_B_SR2 +: 2]);
    stage_n[3] = 5'(5'h02 + 5'(cfg.sysref_sel[DPD_B_SR3 +: 2]));
    pow_sum = 3'(3'(cfg.sysref_sel[DPD_B_SR0]) + 3'(cfg.sysref_sel[DPD_B_SR1 +: 2])
      + 3'(cfg.sysref_sel[DPD_B_SR2 +: 2]));
    sysref_val = 16'((16'h0008 << pow_sum) * 16'(stage_n[3])); // see RL6
  end

  // register writes and read-back
  always_comb
  begin
    next_cfg = cfg;
    next_chan_div = chan_div;
    next_rdata = '0;
    next_path_clr = 1'b0;
    if (wr_i)
    begin
      case (addr_i)
        DPD_A_CTRL:
        begin
          next_cfg.first_loop_bypass = wdata_i[DPD_B_BYPASS];
          next_cfg.feedback_route_select = wdata_i[DPD_B_ROUTE];
          next_cfg.doubler_enable = wdata_i[DPD_B_DOUBLER];
          next_cfg.monitor_div_powerdown = wdata_i[DPD_B_MON_PD];
          next_cfg.cp_code = wdata_i[DPD_B_CP_LSB +: DPD_CP_W]; // see RL16
          next_path_clr = 1'b1;
        end
        DPD_A_INPUT_PRESCALE:
          next_cfg.input_prescale_div =
            DPD_PV_W'(dpd_clamp(wdata_i, DPD_PV_MIN, DPD_PV_MAX)); // see RL1
        DPD_A_FIRST_FB:
          next_cfg.first_loop_feedback_div =
            DPD_MV0_W'(dpd_clamp(wdata_i, DPD_MV0_MIN, DPD_MV0_MAX)); // see RL2
        DPD_A_MONITOR_FB:
          next_cfg.monitor_feedback_div =
            DPD_MV1_W'(dpd_clamp(wdata_i, DPD_MV1_MIN, DPD_MV1_MAX)); // see RL2
        DPD_A_SECOND_PREDIV:
          next_cfg.second_loop_prediv =
            DPD_PF_W'(dpd_clamp(wdata_i, DPD_PF_MIN, DPD_PF_MAX)); // see RL3
        DPD_A_SECOND_FB:
          next_cfg.second_loop_feedback_div =
            DPD_MF_W'(dpd_clamp(wdata_i, DPD_MF_MIN, DPD_MF_MAX)); // see RL4
        DPD_A_SYSREF_SEL:
          next_cfg.sysref_sel = wdata_i[6:0];
        default:
        begin
          for (int i = 0; i < DPD_NCHAN; i++)
          begin
            if (addr_i == 8'(DPD_A_CHAN_BASE + 8'(i)))
            begin
              next_chan_div[i] =
                DPD_NX_W'(dpd_clamp(wdata_i, DPD_NX_MIN, DPD_NX_MAX)); // see RL5
            end
          end
        end
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        DPD_A_CTRL:
          next_rdata = 16'({cfg.cp_code, cfg.monitor_div_powerdown, cfg.doubler_enable,
            cfg.feedback_route_select, cfg.first_loop_bypass});
        DPD_A_INPUT_PRESCALE: next_rdata = 16'(cfg.input_prescale_div);
        DPD_A_FIRST_FB: next_rdata = 16'(cfg.first_loop_feedback_div);
        DPD_A_MONITOR_FB: next_rdata = 16'(cfg.monitor_feedback_div);
        DPD_A_SECOND_PREDIV: next_rdata = 16'(cfg.second_loop_prediv);
        DPD_A_SECOND_FB: next_rdata = 16'(cfg.second_loop_feedback_div);
        DPD_A_SYSREF_SEL: next_rdata = 16'(cfg.sysref_sel);
        DPD_A_STATUS:
          next_rdata = 16'({!cfg.monitor_div_powerdown,
            !cfg.doubler_enable, !cfg.first_loop_bypass});
        DPD_A_SYSREF_VAL: next_rdata = sysref_val;
        default:
        begin
          for (int i = 0; i < DPD_NCHAN; i++)
          begin
            if (addr_i == 8'(DPD_A_CHAN_BASE + 8'(i)))
            begin
              next_rdata = 16'(chan_div[i]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg <= '{first_loop_bypass: 1'b0, feedback_route_select: 1'b0, doubler_enable: 1'b0,
        monitor_div_powerdown: 1'b0, cp_code: DPD_RST_CP, input_prescale_div: DPD_RST_PV,
        first_loop_feedback_div: DPD_RST_MV0, monitor_feedback_div: DPD_RST_MV1,
        second_loop_prediv: DPD_RST_PF, second_loop_feedback_div: DPD_RST_MF,
        sysref_sel: DPD_RST_SR};
      for (int i = 0; i < DPD_NCHAN; i++)
      begin
        chan_div[i] <= DPD_RST_NX;
      end
      rdata <= '0;
      path_clr <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      chan_div <= next_chan_div;
      rdata <= next_rdata;
      path_clr <= next_path_clr;
    end
  end

  // first loop: prescaler always runs, it feeds the second loop in bypass
  dpd_pdiv #(.W(DPD_PV_W)) u_pv (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(1'b1), .clr_i(path_clr),
    .n_i(cfg.input_prescale_div), .tick_i(ref_tick_i), .tick_o(pv_tick)); // see RL1

  // monitor divider on the oscillator, stopped when powered down
  dpd_pdiv #(.W(DPD_MV1_W)) u_mv1 (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(!cfg.monitor_div_powerdown),
    .clr_i(path_clr), .n_i(cfg.monitor_feedback_div), .tick_i(vco_tick_i),
    .tick_o(mv1_tick)); // see RL2

  // feedback source: external oscillator alone, or cascade via monitor divider
  assign mv0_src = cfg.feedback_route_select ? mv1_tick : vcxo_tick_i; // see RL9 see RL10

  dpd_pdiv #(.W(DPD_MV0_W)) u_mv0 (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(!cfg.first_loop_bypass),
    .clr_i(path_clr), .n_i(cfg.first_loop_feedback_div), .tick_i(mv0_src),
    .tick_o(mv0_tick)); // see RL7

  // second loop reference source
  assign second_src = cfg.first_loop_bypass ? pv_tick : vcxo_tick_i; // see RL7

  dpd_pdiv #(.W(DPD_PF_W)) u_pf (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(!cfg.doubler_enable),
    .clr_i(path_clr), .n_i(cfg.second_loop_prediv), .tick_i(second_src),
    .tick_o(pf_tick)); // see RL3 see RL18

  // doubler: source tick plus one more at half the last measured period
  always_comb
  begin
    next_per_cnt = per_cnt;
    next_half_per = half_per;
    next_dbl_extra = 1'b0;
    if (!cfg.doubler_enable || path_clr)
    begin
      next_per_cnt = '0;
      next_half_per = '0;
    end
    else if (second_src)
    begin
      next_per_cnt = DPD_PER_W'(1);
      next_half_per = DPD_PER_W'(per_cnt >> 1);
    end
    else
    begin
      if (per_cnt != '1)
      begin
        next_per_cnt = DPD_PER_W'(per_cnt + DPD_PER_W'(1));
      end
      next_dbl_extra = (half_per != '0) && (per_cnt == half_per); // see RL13
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      per_cnt <= '0;
      half_per <= '0;
      dbl_extra <= 1'b0;
    end
    else
    begin
      per_cnt <= next_per_cnt;
      half_per <= next_half_per;
      dbl_extra <= next_dbl_extra;
    end
  end

  assign dbl_tick = cfg.doubler_enable && dbl_extra; // see RL18

  // second loop feedback always through its own divider
  dpd_pdiv #(.W(DPD_MF_W)) u_mf (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(1'b1), .clr_i(path_clr),
    .n_i(cfg.second_loop_feedback_div), .tick_i(vco_tick_i), .tick_o(mf_tick)); // see RL9

  // channel dividers
  for (genvar c = 0; c < DPD_NCHAN; c++)
  begin : g_chan
    dpd_pdiv #(.W(DPD_NX_W)) u_nx (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(1'b1), .clr_i(1'b0),
      .n_i(chan_div[c]), .tick_i(vco_tick_i), .tick_o(channel_tick_o[c])); // see RL5
  end

  // sysref cascade of four factor stages
  assign stage_tick[0] = vco_tick_i;
  for (genvar s = 0; s < DPD_NSTAGE; s++)
  begin : g_sysref
    dpd_pdiv #(.W(5)) u_ns (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(1'b1), .clr_i(1'b0),
      .n_i(stage_n[s]), .tick_i(stage_tick[s]), .tick_o(stage_tick[s+1])); // see RL6
  end

  // doubled path: registered so source and extra ticks align to one cycle
  logic second_ref;
  logic next_second_ref;
  always_comb
  begin
    next_second_ref = cfg.doubler_enable ? (second_src || dbl_tick) : 1'b0;
  end
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      second_ref <= 1'b0;
    end
    else
    begin
      second_ref <= next_second_ref;
    end
  end

  assign rdata_o = rdata;
  assign first_loop_enable_o = !cfg.first_loop_bypass; // see RL7
  assign cp_code_o = cfg.cp_code; // see RL16
  assign ticks_o.first_loop_pfd_ref = pv_tick && !cfg.first_loop_bypass;
  assign ticks_o.first_loop_pfd_fb = mv0_tick;
  assign ticks_o.monitor_ref = mv1_tick;
  assign ticks_o.second_loop_pfd_ref = cfg.doubler_enable ? second_ref : pf_tick; // see RL13
  assign ticks_o.second_loop_pfd_fb = mf_tick;
  assign ticks_o.sysref_tick = stage_tick[DPD_NSTAGE];
endmodule

// *** inc/dpd_pkg.sv ***
/*
  dpd_pkg: register map, field layout, reset values, divider limits
  and the configuration carrier for the dual-loop divider path.
  Assumes a single 100 MHz system clock and a 16-bit register port.
*/
package dpd_pkg;

  localparam int unsigned DPD_AW = 8;
  localparam int unsigned DPD_DW = 16;

  // word addresses
  localparam logic [7:0] DPD_A_CTRL = 8'h00;
  localparam logic [7:0] DPD_A_INPUT_PRESCALE = 8'h01;
  localparam logic [7:0] DPD_A_FIRST_FB = 8'h02;
  localparam logic [7:0] DPD_A_MONITOR_FB = 8'h03;
  localparam logic [7:0] DPD_A_SECOND_PREDIV = 8'h04;
  localparam logic [7:0] DPD_A_SECOND_FB = 8'h05;
  localparam logic [7:0] DPD_A_CHAN_BASE = 8'h06;
  localparam logic [7:0] DPD_A_SYSREF_SEL = 8'h0B;
  localparam logic [7:0] DPD_A_STATUS = 8'h0C;
  localparam logic [7:0] DPD_A_SYSREF_VAL = 8'h0D;

  // control field positions
  localparam int unsigned DPD_B_BYPASS = 0;
  localparam int unsigned DPD_B_ROUTE = 1;
  localparam int unsigned DPD_B_DOUBLER = 2;
  localparam int unsigned DPD_B_MON_PD = 3;
  localparam int unsigned DPD_B_CP_LSB = 4;
  localparam int unsigned DPD_CP_W = 5;

  // sysref select field positions
  localparam int unsigned DPD_B_SR0 = 0;
  localparam int unsigned DPD_B_SR1 = 1;
  localparam int unsigned DPD_B_SR2 = 3;
  localparam int unsigned DPD_B_SR3 = 5;

  localparam int unsigned DPD_NCHAN = 5;
  localparam int unsigned DPD_NSTAGE = 4;

  // divider widths and limits
  localparam int unsigned DPD_PV_W = 12;
  localparam int unsigned DPD_MV0_W = 12;
  localparam int unsigned DPD_MV1_W = 9;
  localparam int unsigned DPD_PF_W = 6;
  localparam int unsigned DPD_MF_W = 9;
  localparam int unsigned DPD_NX_W = 8;
  localparam logic [15:0] DPD_PV_MIN = 16'h0001;
  localparam logic [15:0] DPD_PV_MAX = 16'h0FFF;
  localparam logic [15:0] DPD_MV0_MIN = 16'h0001;
  localparam logic [15:0] DPD_MV0_MAX = 16'h0FFF;
  localparam logic [15:0] DPD_MV1_MIN = 16'h0004;
  localparam logic [15:0] DPD_MV1_MAX = 16'h01FF;
  localparam logic [15:0] DPD_PF_MIN = 16'h0001;
  localparam logic [15:0] DPD_PF_MAX = 16'h003F;
  localparam logic [15:0] DPD_MF_MIN = 16'h0008;
  localparam logic [15:0] DPD_MF_MAX = 16'h01FF;
  localparam logic [15:0] DPD_NX_MIN = 16'h0001;
  localparam logic [15:0] DPD_NX_MAX = 16'h00A0;

  // charge pump: current = (code + 1) * step, 50 uA .. 1.6 mA
  localparam int unsigned DPD_CP_STEP_UA = 50;

  // reset values
  localparam logic [11:0] DPD_RST_PV = 12'h001;
  localparam logic [11:0] DPD_RST_MV0 = 12'h001;
  localparam logic [8:0] DPD_RST_MV1 = 9'h018;
  localparam logic [5:0] DPD_RST_PF = 6'h01;
  localparam logic [8:0] DPD_RST_MF = 9'h014;
  localparam logic [7:0] DPD_RST_NX = 8'h01;
  localparam logic [4:0] DPD_RST_CP = 5'h00;
  localparam logic [6:0] DPD_RST_SR = 7'h00;

  // doubler period counter width
  localparam int unsigned DPD_PER_W = 16;

  typedef struct packed {
    logic first_loop_bypass;
    logic feedback_route_select;
    logic doubler_enable;
    logic monitor_div_powerdown;
    logic [4:0] cp_code;
    logic [11:0] input_prescale_div;
    logic [11:0] first_loop_feedback_div;
    logic [8:0] monitor_feedback_div;
    logic [5:0] second_loop_prediv;
    logic [8:0] second_loop_feedback_div;
    logic [6:0] sysref_sel;
  } dpd_cfg_t;

  typedef struct packed {
    logic first_loop_pfd_ref;
    logic first_loop_pfd_fb;
    logic monitor_ref;
    logic second_loop_pfd_ref;
    logic second_loop_pfd_fb;
    logic sysref_tick;
  } dpd_ticks_t;

  function automatic logic [15:0] dpd_clamp(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo)
    begin
      r = lo;
    end
    else if (v > hi)
    begin
      r = hi;
    end
    return r;
  endfunction

endpackage

// *** verif/dpd_src_model.sv ***
/*
  dpd_src_model: reference, external and internal oscillator edges as
  one-cycle ticks at set periods in clock cycles.
  Assumes periods of at least 1; ticks stop while en_i is low.
*/
`timescale 1ns/1ps

module dpd_src_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // control
  input wire logic en_i,
  input wire logic [23:0] per_i,
  // ticks: bit0 ref, bit1 vcxo, bit2 vco
  output logic [2:0] tick_o
);
  logic [7:0] cnt [3];
  // phase restarts with every enable, so tick counts are exact
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!reset_n_i || !en_i)
      begin
        cnt[i] <= 8'h00;
        tick_o[i] <= 1'b0;
      end
      else
      begin
        tick_o[i] <= (cnt[i] == per_i[8*i+:8] - 8'h01);
        cnt[i] <= (cnt[i] == per_i[8*i+:8] - 8'h01) ? 8'h00 : cnt[i] + 8'h01;
      end
    end
  end
endmodule

// *** verif/dpd_top_asserts.sv ***
/*
  dpd_top_asserts: port-level checks of the divider path.
  Assumes ticks from the source model, one per source per cycle.
*/
`timescale 1ns/1ps

module dpd_top_asserts (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [dpd_pkg::DPD_AW-1:0] addr_i,
  input wire logic [dpd_pkg::DPD_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [dpd_pkg::DPD_DW-1:0] rdata_o,
  // ticks
  input wire logic ref_tick_i,
  input wire logic vcxo_tick_i,
  input wire logic vco_tick_i,
  input wire logic first_loop_enable_o,
  input wire logic [dpd_pkg::DPD_CP_W-1:0] cp_code_o,
  input wire dpd_pkg::dpd_ticks_t ticks_o,
  input wire logic [dpd_pkg::DPD_NCHAN-1:0] channel_tick_o
);
  import dpd_pkg::*;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of the last control word written
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_i && addr_i == DPD_A_CTRL)
    begin
      next_ctrl = wdata_i;
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl <= 16'h0000;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end
  a_rdata_one_cycle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  a_loop_enable_bypass: assert property (first_loop_enable_o == !ctrl[0])
    else $error("first loop enable wrong");
  a_cp_code_field: assert property (cp_code_o == ctrl[8:4])
    else $error("charge pump code wrong");
  a_bypass_gates_ref: assert property (ctrl[0] && $past(ctrl[0]) |->
    !ticks_o.first_loop_pfd_ref) else $error("ref pulse while bypassed");
  a_prescale_cause: assert property (ticks_o.first_loop_pfd_ref |-> $past(ref_tick_i))
    else $error("prescaler pulse without ref tick");
  a_mf_pulse_shape: assert property (ticks_o.second_loop_pfd_fb |->
    $past(vco_tick_i) ##1 !ticks_o.second_loop_pfd_fb) else $error("feedback pulse wrong");
  a_chan_cause: assert property (|channel_tick_o |-> $past(vco_tick_i))
    else $error("channel pulse without vco tick");
  a_sysref_cascade: assert property (ticks_o.sysref_tick |->
    $past(vco_tick_i, 4) ##1 !ticks_o.sysref_tick) else $error("sysref pulse wrong");
  a_monitor_powerdown: assert property (ctrl[3] && $past(ctrl[3]) |->
    !ticks_o.monitor_ref) else $error("monitor pulse while powered down");
  c_bypass: cover property (ctrl[0] && ticks_o.second_loop_pfd_ref);
  c_route: cover property (ctrl[1] && ticks_o.first_loop_pfd_fb);
  c_doubler: cover property (ctrl[2] && ticks_o.second_loop_pfd_ref);
endmodule

bind dpd_top dpd_top_asserts u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .ref_tick_i(ref_tick_i), .vcxo_tick_i(vcxo_tick_i), .vco_tick_i(vco_tick_i),
  .first_loop_enable_o(first_loop_enable_o), .cp_code_o(cp_code_o),
  .ticks_o(ticks_o), .channel_tick_o(channel_tick_o));

// *** verif/test_dual_pll_divider_path_config.sv ***
/*
  test_dual_pll_divider_path_config: register and divider scenarios.
  Assumes the source model for ticks and the checker bound to dpd_top.
*/
`timescale 1ns/1ps

module test_dual_pll_divider_path_config;
  import dpd_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [2:0] tick;
  logic en = 1'b0;
  logic cnt_clr = 1'b0;
  logic first_loop_enable_o;
  logic [4:0] cp_code_o;
  dpd_ticks_t ticks_o;
  logic [4:0] channel_tick_o;
  logic [15:0] cnt [11];
  logic [15:0] v;
  int num_errors = 0;
  int tests_run = 0;
  always #5 mclk_i = ~mclk_i;
  dpd_src_model u_src (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(en),
    .per_i(24'h01_0802), .tick_o(tick));
  dpd_top DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ref_tick_i(tick[0]), .vcxo_tick_i(tick[1]), .vco_tick_i(tick[2]),
    .first_loop_enable_o(first_loop_enable_o), .cp_code_o(cp_code_o),
    .ticks_o(ticks_o), .channel_tick_o(channel_tick_o));
  // pulse counters, cleared only here so they keep a single driver
  always @(posedge mclk_i)
  begin
    if (cnt_clr)
    begin
      for (int i = 0; i < 11; i++)
      begin
        cnt[i] <= 16'h0000;
      end
    end
    else
    begin
      cnt[0] <= cnt[0] + ticks_o.first_loop_pfd_ref;
      cnt[1] <= cnt[1] + ticks_o.first_loop_pfd_fb;
      cnt[2] <= cnt[2] + ticks_o.monitor_ref;
      cnt[3] <= cnt[3] + ticks_o.second_loop_pfd_ref;
      cnt[4] <= cnt[4] + ticks_o.second_loop_pfd_fb;
      cnt[5] <= cnt[5] + ticks_o.sysref_tick;
      for (int i = 0; i < 5; i++)
      begin
        cnt[6+i] <= cnt[6+i] + channel_tick_o[i];
      end
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // 480 clock cycles of ticks: 240 ref, 60 vcxo, 480 vco
  task automatic run(input logic [15:0] ctrl);
    wr(DPD_A_CTRL, ctrl);
    @(posedge mclk_i);
    cnt_clr <= 1'b1;
    en <= 1'b1;
    @(posedge mclk_i);
    cnt_clr <= 1'b0;
    repeat (479) @(posedge mclk_i);
    en <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask
  task automatic finish_test;
    if (num_errors == 0 && tests_run > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [15:0] e [15];
    e = '{16'h0, 16'h1, 16'h1, 16'h18, 16'h1, 16'h14, 16'h1, 16'h1, 16'h1, 16'h1,
      16'h1, 16'h0, 16'h7, 16'h10, 16'h0};
    for (int i = 0; i < 14; i++)
    begin
      rdchk(i[7:0], e[i]);
    end
    rdchk(8'h20, 16'h0000);
    chk({15'h0, first_loop_enable_o}, 16'h0001);
  endtask
  task automatic t_clamp;
    logic [7:0] a [8];
    logic [15:0] d [8];
    logic [15:0] e [8];
    a = '{8'h01, 8'h01, 8'h03, 8'h04, 8'h04, 8'h05, 8'h05, 8'h06};
    d = '{16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h40, 16'h0, 16'h3FF, 16'hC8};
    e = '{16'h1, 16'hFFF, 16'h4, 16'h1, 16'h3F, 16'h8, 16'h1FF, 16'hA0};
    for (int i = 0; i < 8; i++)
    begin
      wr(a[i], d[i]);
      rdchk(a[i], e[i]);
    end
    wr(DPD_A_SYSREF_SEL, 16'h007F);
    rdchk(DPD_A_SYSREF_VAL, 16'd5120);
    wr(DPD_A_SYSREF_SEL, 16'h002B);
    rdchk(DPD_A_SYSREF_VAL, 16'd192);
    wr(DPD_A_STATUS, 16'h0000);
    rdchk(DPD_A_STATUS, 16'h0007);
  endtask
  task automatic t_divide;
    logic [15:0] n [5];
    n = '{16'd1, 16'd2, 16'd3, 16'd5, 16'd160};
    wr(DPD_A_SYSREF_SEL, 16'h0000);
    wr(DPD_A_INPUT_PRESCALE, 16'd4);
    wr(DPD_A_FIRST_FB, 16'd3);
    wr(DPD_A_MONITOR_FB, 16'd4);
    wr(DPD_A_SECOND_PREDIV, 16'd1);
    wr(DPD_A_SECOND_FB, 16'd20);
    for (int i = 0; i < 5; i++)
    begin
      wr(DPD_A_CHAN_BASE + i[7:0], n[i]);
    end
    run(16'h0000);
    chk(cnt[0], 16'd60);
    chk(cnt[1], 16'd20);
    chk(cnt[2], 16'd120);
    chk(cnt[3], 16'd60);
    chk(cnt[4], 16'd24);
    chk(cnt[5], 16'd30);
    for (int i = 0; i < 5; i++)
    begin
      chk(cnt[6+i], 16'd480 / n[i]);
    end
  endtask
  task automatic t_modes;
    run(16'h0002);
    chk(cnt[1], 16'd40);
    run(16'h0001);
    chk({15'h0, first_loop_enable_o}, 16'h0000);
    chk(cnt[0], 16'd0);
    chk(cnt[1], 16'd0);
    chk(cnt[3], 16'd60);
    wr(DPD_A_SECOND_PREDIV, 16'd3);
    run(16'h0004);
    chk({15'h0, cnt[3] > 16'd117 && cnt[3] < 16'd123}, 16'h0001);
    run(16'h01F8);
    chk(cnt[3], 16'd20);
    chk(cnt[2], 16'd0);
    chk(cnt[1], 16'd20);
    chk({11'h0, cp_code_o}, 16'h001F);
    rdchk(DPD_A_CTRL, 16'h01F8);
    rdchk(DPD_A_STATUS, 16'h0003);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_clamp();
    t_divide();
    t_modes();
    finish_test();
  end
endmodule
